// ==== step_sequence_engine.sv ====
// step sequence engine: step control, timers, pulses, remote blocks
`timescale 1ns/1ps
`default_nettype none
module step_sequence_engine
    import step_seq_pkg::*;
#(
    parameter logic [9:0] SELF_ADDR  = 10'h190,
    parameter int         SEC_CYC    = SEC_CYCLES
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 cycle_tick_i,
    input  wire logic                 prog_start_i,
    input  wire blk_cmd_t             in_start_i,
    input  wire logic                 in_stop_i,
    input  wire logic                 step_hold_switch_i,
    input  wire logic                 final_cond_i,
    input  wire blk_cmd_t             jump_i,
    input  wire blk_cmd_t             bset_i,
    input  wire blk_cmd_t             rset_i,
    input  wire logic                 adv_en_i,
    input  wire logic [TMR_W-1:0]     adv_time_i,
    input  wire logic                 watch_en_i,
    input  wire logic [TMR_W-1:0]     watch_time_i,
    input  wire logic [EDGE_N-1:0]    edge_cond_i,
    input  wire logic [CONTACT_N-1:0] coil_on_i,
    input  wire logic [CONTACT_N-1:0] coil_off_i,
    input  wire out_wr_t              out_wr_i,
    input  wire logic [ITEM_W-1:0]    sw_rd_addr_i,
    output logic                      eval_strobe_o,
    output logic                      run_stop_command_o,
    output logic [STEP_W-1:0]         active_step_o,
    output logic                      congestion_o,
    output logic [EDGE_N-1:0]         rising_edge_pulse_o,
    output logic [EDGE_N-1:0]         falling_edge_pulse_o,
    output logic [CONTACT_N-1:0]      contact_o,
    output blk_cmd_t                  remote_start_o,
    output blk_cmd_t                  remote_block_stop_o,
    output out_wr_t                   ext_wr_o,
    output logic                      sw_rd_data_o
);
    seq_state_t st_q;
    seq_state_t st_d;
    logic       act;
    logic       trans;
    logic       adv_exp;
    logic       watch_exp;
    logic       adv_raw;
    logic       watch_raw;
    logic       sw_wr;

    if (SELF_ADDR < BLK_LO || SELF_ADDR > BLK_HI) begin : g_bad_addr
        $error("step_sequence_engine: SELF_ADDR outside 400..499");
    end
    if (SEC_CYC < 1) begin : g_bad_sec
        $error("step_sequence_engine: SEC_CYC must be positive");
    end

    function automatic logic step_ok(input logic [STEP_W-1:0] s);
        return (s >= STEP_FIRST) && (s <= STEP_LAST);
    endfunction : step_ok

    function automatic logic is_self(input logic [BLK_W-1:0] b);
        return (b == BLK_SELF) || (b == SELF_ADDR);
    endfunction : is_self

    function automatic logic is_remote(input logic [BLK_W-1:0] b);
        return (b >= BLK_LO) && (b <= BLK_HI) && (b != SELF_ADDR);
    endfunction : is_remote

    // the active step is evaluated on this strobe
    // hold pauses evaluation
    assign act       = cycle_tick_i && st_q.run && !step_hold_switch_i;
    assign adv_exp   = adv_en_i && adv_raw;
    assign watch_exp = watch_en_i && watch_raw;
    assign sw_wr     = act && out_wr_i.req && out_wr_i.model == SW_MODEL;

    always_comb begin
        st_d           = st_q;
        trans          = 1'b0;
        st_d.rs.req    = 1'b0;
        st_d.rstop.req = 1'b0;
        st_d.ext.req   = 1'b0;
        st_d.sec       = 1'b0;
        if (st_q.pre >= PRE_W'(SEC_CYC - 1)) begin
            st_d.pre = '0;
            st_d.sec = 1'b1;
        end else begin
            st_d.pre = st_q.pre + 32'h0000_0001;
        end
        if (act) begin
            st_d.prev = edge_cond_i;
            st_d.rise = edge_cond_i & ~st_q.prev;
            st_d.fall = ~edge_cond_i & st_q.prev;
            st_d.contact = (st_q.contact & ~coil_off_i) | coil_on_i;
            if (out_wr_i.req && out_wr_i.model != SW_MODEL) begin
                st_d.ext = out_wr_i;
            end
            if (jump_i.req && step_ok(jump_i.step)
                && (is_self(jump_i.blk) || is_remote(jump_i.blk))) begin
                if (is_self(jump_i.blk)) begin
                    st_d.step = jump_i.step;
                    trans     = 1'b1;
                end else begin
                    st_d.run = 1'b0;
                    st_d.rs  = jump_i;
                end
            end else if (!st_q.cong && final_cond_i) begin
                st_d.step = (st_q.step == STEP_LAST) ? STEP_LAST
                          : st_q.step + 7'h01;
                trans     = 1'b1;
            end else if (!st_q.cong && adv_exp) begin
                st_d.step = (st_q.step == STEP_LAST) ? STEP_LAST
                          : st_q.step + 7'h01;
                trans     = 1'b1;
            end
            // remote start, loses to a remote jump
            if (bset_i.req && is_remote(bset_i.blk)
                && step_ok(bset_i.step) && !st_d.rs.req) begin
                st_d.rs = bset_i;
            end
            if (rset_i.req && is_self(rset_i.blk)) begin
                st_d.run = 1'b0;
            end else if (rset_i.req && is_remote(rset_i.blk)) begin
                st_d.rstop = rset_i;
            end
        end else if (cycle_tick_i) begin
            st_d.rise = '0;
            st_d.fall = '0;
        end
        if (in_stop_i) begin
            st_d.run = 1'b0;
        end
        if (in_start_i.req && step_ok(in_start_i.step)) begin
            st_d.run  = 1'b1;
            st_d.step = in_start_i.step;
            trans     = 1'b1;
        end
        if (prog_start_i) begin
            st_d.run  = 1'b1;
            st_d.step = STEP_FIRST;
            trans     = 1'b1;
        end
        // congestion flag, new step starts clean
        if (trans) begin
            st_d.cong = 1'b0;
        end else if (watch_exp && st_q.run) begin
            st_d.cong = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_q      <= '0;
            st_q.step <= STEP_FIRST;
        end else begin
            st_q <= st_d;
        end
    end

    step_timer u_adv (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .restart_i  (trans),
        .sec_i      (st_q.sec && st_q.run && !step_hold_switch_i),
        .limit_i    (adv_time_i > TMR_MAX ? TMR_MAX : adv_time_i),
        .expired_o  (adv_raw)
    );

    step_timer u_watch (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .restart_i  (trans),
        .sec_i      (st_q.sec && st_q.run && !step_hold_switch_i),
        .limit_i    (watch_time_i > TMR_MAX ? TMR_MAX : watch_time_i),
        .expired_o  (watch_raw)
    );

    sw_store #(
        .DEPTH (1 << ITEM_W),
        .AW    (ITEM_W)
    ) u_sw (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .wr_en_i    (sw_wr),
        .wr_addr_i  (out_wr_i.item),
        .wr_data_i  (out_wr_i.val),
        .rd_addr_i  (sw_rd_addr_i),
        .rd_data_o  (sw_rd_data_o)
    );

    assign eval_strobe_o        = act;
    assign run_stop_command_o   = st_q.run;
    assign active_step_o        = st_q.step;
    assign congestion_o         = st_q.cong;
    assign rising_edge_pulse_o  = st_q.rise;
    assign falling_edge_pulse_o = st_q.fall;
    assign contact_o            = st_q.contact;
    assign remote_start_o       = st_q.rs;
    assign remote_block_stop_o  = st_q.rstop;
    assign ext_wr_o             = st_q.ext;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic quiet;
    assign quiet = !prog_start_i && !in_start_i.req && !in_stop_i;

    property p_rise_pulse;
        act && edge_cond_i[0] && !st_q.prev[0] |=> rising_edge_pulse_o[0];
    endproperty
    a_rise_pulse: assert property (p_rise_pulse)
        else $error("rising pulse missing");

    property p_pulse_clear;
        cycle_tick_i && !act |=> rising_edge_pulse_o == '0
                                 && falling_edge_pulse_o == '0;
    endproperty
    a_pulse_clear: assert property (p_pulse_clear)
        else $error("edge pulse not cleared");

    property p_contact_hold;
        contact_o[0] && !(act && coil_off_i[0]) |=> contact_o[0];
    endproperty
    a_contact_hold: assert property (p_contact_hold)
        else $error("contact dropped without reset");

    property p_step_range;
        run_stop_command_o |-> step_ok(active_step_o);
    endproperty
    a_step_range: assert property (p_step_range)
        else $error("active step out of range");

    property p_cond_adv;
        act && final_cond_i && !jump_i.req && !congestion_o && quiet
        && active_step_o < STEP_LAST
        |=> active_step_o == $past(active_step_o) + 7'h01;
    endproperty
    a_cond_adv: assert property (p_cond_adv)
        else $error("no advance on final condition");

    property p_hold;
        step_hold_switch_i && quiet |=> $stable(active_step_o)
                                       && $stable(contact_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("step moved during hold");

    property p_cong_hold;
        congestion_o && quiet && !(act && jump_i.req)
        |=> $stable(active_step_o);
    endproperty
    a_cong_hold: assert property (p_cong_hold)
        else $error("step moved while congested");

    property p_cong_set;
        watch_exp && run_stop_command_o && !trans |=> congestion_o;
    endproperty
    a_cong_set: assert property (p_cong_set)
        else $error("congestion flag not set");

    property p_jump_remote;
        act && jump_i.req && is_remote(jump_i.blk) && step_ok(jump_i.step)
        && quiet |=> !run_stop_command_o && remote_start_o.req
                     && remote_start_o.blk == $past(jump_i.blk);
    endproperty
    a_jump_remote: assert property (p_jump_remote)
        else $error("remote jump hand-over wrong");

    property p_rset;
        act && rset_i.req && is_remote(rset_i.blk)
        |=> remote_block_stop_o.req ##1 !remote_block_stop_o.req;
    endproperty
    a_rset: assert property (p_rset)
        else $error("remote stop not issued for one cycle");

    property p_adv_timer;
        act && adv_exp && !final_cond_i && !jump_i.req && !congestion_o
        && quiet && active_step_o < STEP_LAST
        |=> active_step_o == $past(active_step_o) + 7'h01;
    endproperty
    a_adv_timer: assert property (p_adv_timer)
        else $error("advance timer did not move step");

    c_start: cover property (prog_start_i ##1 run_stop_command_o);
    c_adv: cover property (act && final_cond_i ##1 active_step_o == 7'h02);
    c_cong: cover property (!congestion_o ##1 congestion_o);
    c_jump: cover property (remote_start_o.req && !run_stop_command_o);
endmodule : step_sequence_engine
`default_nettype wire

// ==== step_seq_pkg.sv ====
// shared constants and carrier types of the step sequence engine
package step_seq_pkg;
    localparam int          STEP_W     = 7;
    localparam int          BLK_W      = 10;
    localparam int          ITEM_W     = 8;
    localparam int          TMR_W      = 14;
    localparam int          EDGE_N     = 8;
    localparam int          CONTACT_N  = 8;
    localparam int          PRE_W      = 32;
    localparam logic [6:0]  STEP_FIRST = 7'h01;
    localparam logic [6:0]  STEP_LAST  = 7'h63;
    localparam logic [9:0]  BLK_SELF   = 10'h000;
    localparam logic [9:0]  BLK_LO     = 10'h190;
    localparam logic [9:0]  BLK_HI     = 10'h1f3;
    localparam logic [9:0]  SW_MODEL   = 10'h0d1;
    localparam logic [13:0] TMR_MAX    = 14'h270f;
    // one second of timer resolution
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          SEC_NS        = 1_000_000_000;
    localparam int          SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic              req;
        logic [BLK_W-1:0]  blk;
        logic [STEP_W-1:0] step;
    } blk_cmd_t;

    typedef struct packed {
        logic              req;
        logic [BLK_W-1:0]  model;
        logic [ITEM_W-1:0] item;
        logic              val;
    } out_wr_t;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic             done;
    } tmr_state_t;

    typedef struct packed {
        logic                 run;
        logic [STEP_W-1:0]    step;
        logic                 cong;
        logic [EDGE_N-1:0]    prev;
        logic [EDGE_N-1:0]    rise;
        logic [EDGE_N-1:0]    fall;
        logic [CONTACT_N-1:0] contact;
        blk_cmd_t             rs;
        blk_cmd_t             rstop;
        out_wr_t              ext;
        logic [PRE_W-1:0]     pre;
        logic                 sec;
    } seq_state_t;
endpackage : step_seq_pkg

// ==== step_timer.sv ====
// per-step seconds timer, restarted on every step change
`timescale 1ns/1ps
`default_nettype none
module step_timer
    import step_seq_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             restart_i,
    input  wire logic             sec_i,
    input  wire logic [TMR_W-1:0] limit_i,
    output logic                  expired_o
);
    tmr_state_t st_q;
    tmr_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (restart_i) begin
            st_d.cnt = '0;
        end else if (sec_i && st_q.cnt < limit_i) begin
            st_d.cnt = st_q.cnt + 14'h0001;
        end
        // a fresh step never shows a stale expiry
        st_d.done = !restart_i && (st_d.cnt >= limit_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign expired_o = st_q.done;
endmodule : step_timer
`default_nettype wire

// ==== sw_store.sv ====
// internal switch store, one bit per item, registered read
`timescale 1ns/1ps
`default_nettype none
module sw_store #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          core_clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic          wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic               rd_data_o
);
    typedef struct packed {
        logic [DEPTH-1:0] bits;
        logic             rd;
    } store_t;

    store_t st_q;
    store_t st_d;

    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("sw_store: DEPTH must equal 2**AW");
    end

    always_comb begin
        st_d    = st_q;
        st_d.rd = st_q.bits[rd_addr_i];
        if (wr_en_i) begin
            st_d.bits[wr_addr_i] = wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_o = st_q.rd;
endmodule : sw_store
`default_nettype wire

// ==== step_block_partner.sv ====
// partner model: a second step program block that also consumes pulses
`timescale 1ns/1ps
`default_nettype none
module step_block_partner
    import step_seq_pkg::*;
#(
    parameter logic [9:0] ADDR = 10'h191
) (
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              cycle_tick_i,
    input  wire blk_cmd_t          start_i,
    input  wire blk_cmd_t          stop_i,
    input  wire logic [EDGE_N-1:0] pulse_i,
    output logic                   run_o,
    output logic [STEP_W-1:0]      step_o,
    output logic [7:0]             pulse_cnt_o
);
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            run_o       <= 1'b0;
            step_o      <= 7'h01;
            pulse_cnt_o <= 8'h00;
        end else begin
            if (start_i.req && start_i.blk == ADDR) begin
                run_o  <= 1'b1;
                step_o <= start_i.step;
            end else if (stop_i.req && stop_i.blk == ADDR) begin
                run_o <= 1'b0;
            end
            // sampled once per own cycle, same rate as sender
            if (cycle_tick_i && pulse_i[0]) begin
                pulse_cnt_o <= pulse_cnt_o + 8'h01;
            end
        end
    end
endmodule : step_block_partner
`default_nettype wire

// ==== tb_step_sequence_engine.sv ====
// self-checking bench of the step sequence engine
`timescale 1ns/1ps
`default_nettype none
module tb_step_sequence_engine
    import step_seq_pkg::*;
;
    logic              core_clk_i, sys_rst_i, cycle_tick_i, prog_start_i;
    logic              in_stop_i, step_hold_switch_i, final_cond_i, strb;
    logic              adv_en_i, watch_en_i, sw_rd_data_o, p_run;
    logic              eval_strobe_o, run_stop_command_o, congestion_o;
    blk_cmd_t          in_start_i, jump_i, bset_i, rset_i;
    blk_cmd_t          remote_start_o, remote_block_stop_o;
    logic [TMR_W-1:0]  adv_time_i, watch_time_i;
    logic [EDGE_N-1:0] edge_cond_i, coil_on_i, coil_off_i, contact_o;
    logic [EDGE_N-1:0] rising_edge_pulse_o, falling_edge_pulse_o;
    out_wr_t           out_wr_i, ext_wr_o;
    logic [ITEM_W-1:0] sw_rd_addr_i;
    logic [STEP_W-1:0] active_step_o, p_step;
    logic [7:0]        p_cnt;
    int                mismatches, checks_done, cyc, n;

    step_sequence_engine #(.SELF_ADDR(10'h190), .SEC_CYC(10)) u_dut (
        .core_clk_i, .sys_rst_i, .cycle_tick_i, .prog_start_i, .in_start_i,
        .in_stop_i, .step_hold_switch_i, .final_cond_i, .jump_i, .bset_i,
        .rset_i, .adv_en_i, .adv_time_i, .watch_en_i, .watch_time_i,
        .edge_cond_i, .coil_on_i, .coil_off_i, .out_wr_i, .sw_rd_addr_i,
        .eval_strobe_o, .run_stop_command_o, .active_step_o, .congestion_o,
        .rising_edge_pulse_o, .falling_edge_pulse_o, .contact_o,
        .remote_start_o, .remote_block_stop_o, .ext_wr_o, .sw_rd_data_o
    );
    step_block_partner #(.ADDR(10'h191)) u_far (
        .core_clk_i, .sys_rst_i, .cycle_tick_i, .start_i(remote_start_o),
        .stop_i(remote_block_stop_o), .pulse_i(rising_edge_pulse_o),
        .run_o(p_run), .step_o(p_step), .pulse_cnt_o(p_cnt)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // generous ceiling, the whole run needs well under a thousand cycles
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic blk_cmd_t cmd(logic [9:0] b, logic [6:0] s);
        return {1'b1, b, s};
    endfunction : cmd

    // one operation cycle; called at a rising edge, one-shot inputs cleared
    task automatic op();
        cycle_tick_i <= 1'b1;
        #1 strb = eval_strobe_o;
        @(posedge core_clk_i);
        cycle_tick_i <= 1'b0;
        final_cond_i <= 1'b0;
        prog_start_i <= 1'b0;
        in_stop_i    <= 1'b0;
        jump_i       <= '0;
        bset_i       <= '0;
        rset_i       <= '0;
        in_start_i   <= '0;
        out_wr_i     <= '0;
        coil_on_i    <= '0;
        coil_off_i   <= '0;
        #1;
    endtask : op

    task automatic t_start_hold();
        @(posedge core_clk_i); prog_start_i <= 1'b1; op();
        check(run_stop_command_o, 1'b1);
        check(active_step_o, 7'h01);
        @(posedge core_clk_i); final_cond_i <= 1'b1; op();
        check(strb, 1'b1);
        check(active_step_o, 7'h02);
        @(posedge core_clk_i); step_hold_switch_i <= 1'b1;
        @(posedge core_clk_i); final_cond_i <= 1'b1; op();
        check(strb, 1'b0);
        check(active_step_o, 7'h02);
        @(posedge core_clk_i); step_hold_switch_i <= 1'b0;
        @(posedge core_clk_i); final_cond_i <= 1'b1; op();
        check(active_step_o, 7'h03);
    endtask : t_start_hold

    task automatic t_jumps();
        @(posedge core_clk_i); jump_i <= cmd(10'h000, 7'h63); op();
        check(active_step_o, 7'h63);
        @(posedge core_clk_i); final_cond_i <= 1'b1; op();
        check(active_step_o, 7'h63);
        @(posedge core_clk_i); jump_i <= cmd(10'h190, 7'h05); op();
        check(active_step_o, 7'h05);
        @(posedge core_clk_i); jump_i <= cmd(10'h191, 7'h0a); op();
        check(run_stop_command_o, 1'b0);
        check(remote_start_o, {1'b1, 10'h191, 7'h0a});
        @(posedge core_clk_i); #1;
        check(remote_start_o.req, 1'b0);
        check({p_run, p_step}, {1'b1, 7'h0a});
    endtask : t_jumps

    task automatic t_blocks();
        @(posedge core_clk_i); prog_start_i <= 1'b1; op();
        @(posedge core_clk_i); bset_i <= cmd(10'h1f3, 7'h07); op();
        check(remote_start_o, {1'b1, 10'h1f3, 7'h07});
        check(run_stop_command_o, 1'b1);
        @(posedge core_clk_i); bset_i <= cmd(10'h191, 7'h20); op();
        @(posedge core_clk_i); #1;
        check(p_step, 7'h20);
        @(posedge core_clk_i); rset_i <= cmd(10'h191, 7'h00); op();
        check({remote_block_stop_o.req, remote_block_stop_o.blk},
              {1'b1, 10'h191});
        @(posedge core_clk_i); #1;
        check(p_run, 1'b0);
    endtask : t_blocks

    task automatic t_pulses();
        @(posedge core_clk_i); edge_cond_i <= 8'h01; op();
        check(rising_edge_pulse_o, 8'h01);
        @(posedge core_clk_i); op();
        check(rising_edge_pulse_o, 8'h00);
        check(p_cnt, 8'h01);
        @(posedge core_clk_i); edge_cond_i <= 8'h00; op();
        check(falling_edge_pulse_o, 8'h01);
        @(posedge core_clk_i); op();
        check(falling_edge_pulse_o, 8'h00);
    endtask : t_pulses

    task automatic t_coils_store();
        @(posedge core_clk_i); coil_on_i <= 8'h05; op();
        check(contact_o, 8'h05);
        @(posedge core_clk_i); final_cond_i <= 1'b1; op();
        check(contact_o, 8'h05);
        @(posedge core_clk_i); coil_off_i <= 8'h01; op();
        check(contact_o, 8'h04);
        @(posedge core_clk_i); out_wr_i <= {1'b1, 10'h0d1, 8'h03, 1'b1}; op();
        check(ext_wr_o.req, 1'b0);
        @(posedge core_clk_i); sw_rd_addr_i <= 8'h03;
        @(posedge core_clk_i); #1;
        check(sw_rd_data_o, 1'b1);
        @(posedge core_clk_i); out_wr_i <= {1'b1, 10'h190, 8'h04, 1'b1}; op();
        check(ext_wr_o, {1'b1, 10'h190, 8'h04, 1'b1});
    endtask : t_coils_store

    // prescaler phase is fixed by reset, so the wait counts are exact
    task automatic t_timers();
        @(posedge core_clk_i); adv_en_i <= 1'b1; adv_time_i <= 14'h0002;
        jump_i <= cmd(10'h000, 7'h10); op();
        for (n = 0; active_step_o === 7'h10 && n < 20; n++) begin
            @(posedge core_clk_i); op();
        end
        check(active_step_o, 7'h11);
        check(n, 11);
        @(posedge core_clk_i); adv_en_i <= 1'b0; watch_en_i <= 1'b1;
        watch_time_i <= 14'h0001; jump_i <= cmd(10'h000, 7'h20); op();
        for (n = 0; congestion_o !== 1'b1 && n < 15; n++) begin
            @(posedge core_clk_i); op();
        end
        check(congestion_o, 1'b1);
        check(n, 4);
        @(posedge core_clk_i); final_cond_i <= 1'b1; op();
        check(active_step_o, 7'h20);
        // watch timer left armed: a missed restart would flag at once
        @(posedge core_clk_i); jump_i <= cmd(10'h000, 7'h30); op();
        check({congestion_o, active_step_o}, {1'b0, 7'h30});
        @(posedge core_clk_i); #1;
        check(congestion_o, 1'b0);
    endtask : t_timers

    task automatic t_inbound();
        @(posedge core_clk_i); in_stop_i <= 1'b1; op();
        check(run_stop_command_o, 1'b0);
        @(posedge core_clk_i); in_start_i <= cmd(10'h000, 7'h09); op();
        check({run_stop_command_o, active_step_o}, {1'b1, 7'h09});
    endtask : t_inbound

    initial begin
        {sys_rst_i, cycle_tick_i, prog_start_i, in_stop_i} = 4'h8;
        {step_hold_switch_i, final_cond_i, adv_en_i, watch_en_i} = 4'h0;
        {in_start_i, jump_i, bset_i, rset_i, out_wr_i} = '0;
        {adv_time_i, watch_time_i, edge_cond_i} = '0;
        {coil_on_i, coil_off_i, sw_rd_addr_i} = '0;
        {mismatches, checks_done} = '0;
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check({run_stop_command_o, active_step_o}, {1'b0, 7'h01});
        check({congestion_o, contact_o}, 9'h000);
        t_start_hold();
        t_jumps();
        t_blocks();
        t_pulses();
        t_coils_store();
        t_timers();
        t_inbound();
        report_and_stop();
    end
endmodule : tb_step_sequence_engine
`default_nettype wire
